// >>> include/abp_pkg.sv
`default_nettype none

// ==========================================================================
// Shared constants for the acknowledge-style host port
package abp_pkg;

  localparam int unsigned ADDR_W               = 7;
  localparam int unsigned DATA_W               = 8;
  localparam int unsigned IRQ_N                = 11;

  // Device may not acknowledge before this many clock edges after enable
  localparam int unsigned ACK_DELAY_EDGES      = 2;
  // Cycles the strap synchroniser needs before its value is trusted
  localparam int unsigned STRAP_SETTLE_CYC     = 3;
  // Host gives up on a missing acknowledge after this many cycles
  localparam int unsigned HOST_ACK_TIMEOUT_CYC = 64;

  // Host request kinds
  localparam logic [1:0]  KIND_READ            = 2'h0;
  localparam logic [1:0]  KIND_WRITE           = 2'h1;
  localparam logic [1:0]  KIND_VECTOR          = 2'h2;

  // Device pin synchroniser word layout
  localparam int unsigned DSY_W                = 19;
  localparam int unsigned DSY_STRAP            = 18;
  localparam int unsigned DSY_IACK             = 17;
  localparam int unsigned DSY_CE               = 16;
  localparam int unsigned DSY_RW               = 15;
  localparam int unsigned DSY_ADDR_LSB         = 8;
  localparam int unsigned DSY_DATA_LSB         = 0;
  localparam logic [18:0] DSY_RST              = 19'h7FFFF;

  // Host pin synchroniser word layout
  localparam int unsigned HSY_W                = 10;
  localparam int unsigned HSY_ACK              = 9;
  localparam int unsigned HSY_IRQ              = 8;
  localparam int unsigned HSY_DATA_LSB         = 0;
  localparam logic [9:0]  HSY_RST              = 10'h3FF;

  localparam logic [7:0]  DATA_RST             = 8'h00;
  localparam logic [6:0]  ADDR_RST             = 7'h00;

  typedef enum logic [3:0] {
    DEV_IDLE  = 4'h1,
    DEV_SETUP = 4'h2,
    DEV_FETCH = 4'h4,
    DEV_ACK   = 4'h8
  } abp_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE    = 4'h1,
    HST_SETUP   = 4'h2,
    HST_WAIT    = 4'h4,
    HST_RELEASE = 4'h8
  } abp_host_state_t;

endpackage

`default_nettype wire

// >>> include/abp_if.sv
`default_nettype none

// ==========================================================================
// Pin bundle between the host and the device; resolves shared wires
interface abp_if;

  logic       chip_enable_low;
  logic       read_not_write;
  logic       vector_fetch_ack_in;
  logic [6:0] register_select_lines;
  logic       bus_style_strap;

  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] host_data_lines;

  logic       transfer_done_ack_oe;
  logic       transfer_done_ack;
  logic       interrupt_request_oe;
  logic       interrupt_request_out;

  // Undriven bus floats high through the pull-ups
  assign host_data_lines       = dev_data_oe ? dev_data_out :
                                 (host_data_oe ? host_data_out : 8'hFF);
  // Open-drain lines: low while pulled, high otherwise
  assign transfer_done_ack     = ~transfer_done_ack_oe;
  assign interrupt_request_out = ~interrupt_request_oe;

  modport device (
    input  chip_enable_low,
    input  read_not_write,
    input  vector_fetch_ack_in,
    input  register_select_lines,
    input  bus_style_strap,
    input  host_data_lines,
    output dev_data_out,
    output dev_data_oe,
    output transfer_done_ack_oe,
    output interrupt_request_oe
  );

  modport host (
    output chip_enable_low,
    output read_not_write,
    output vector_fetch_ack_in,
    output register_select_lines,
    output host_data_out,
    output host_data_oe,
    input  host_data_lines,
    input  transfer_done_ack,
    input  interrupt_request_out
  );

endinterface

`default_nettype wire

// >>> verilog/abp_host.sv
`default_nettype none

// ==========================================================================
// Host end: runs one bus cycle per request and waits for the acknowledge
module abp_host #(
  parameter int unsigned TIMEOUT_CYC = abp_pkg::HOST_ACK_TIMEOUT_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  abp_if.host             bus,
  input  wire logic       req_valid_i,
  input  wire logic [1:0] req_kind_i,
  input  wire logic [6:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  output logic            req_ready_o,
  output logic            done_o,
  output logic            timeout_o,
  output logic [7:0]      rdata_o,
  output logic            irq_pending_o
);

  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_chk
    $error("abp_host: TIMEOUT_CYC out of range");
  end

  // ========================================================================
  // Pin synchroniser
  logic [9:0]  s1_r, s2_r, s3_r, filt_r, filt_nxt;

  always_comb begin
    filt_nxt = (s3_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s1_r   <= abp_pkg::HSY_RST;
      s2_r   <= abp_pkg::HSY_RST;
      s3_r   <= abp_pkg::HSY_RST;
      filt_r <= abp_pkg::HSY_RST;
    end else begin
      s1_r   <= {bus.transfer_done_ack, bus.interrupt_request_out, bus.host_data_lines};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  wire logic       ack_low_w = ~filt_r[abp_pkg::HSY_ACK];
  wire logic [7:0] data_f_w  = filt_r[abp_pkg::HSY_DATA_LSB +: 8];

  // ========================================================================
  // Cycle sequencer
  abp_pkg::abp_host_state_t st_r, st_nxt;
  logic [15:0] tmo_r, tmo_nxt;
  logic        ce_n_r, ce_n_nxt, iack_n_r, iack_n_nxt, rw_r, rw_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic [7:0]  dout_r, dout_nxt, rdata_r, rdata_nxt;
  logic        doe_r, doe_nxt, vec_r, vec_nxt;
  logic        ready_r, ready_nxt, done_r, done_nxt, tmo_p_r, tmo_p_nxt, irq_r, irq_nxt;

  always_comb begin
    st_nxt     = st_r;
    tmo_nxt    = tmo_r;
    ce_n_nxt   = ce_n_r;
    iack_n_nxt = iack_n_r;
    rw_nxt     = rw_r;
    addr_nxt   = addr_r;
    dout_nxt   = dout_r;
    rdata_nxt  = rdata_r;
    doe_nxt    = doe_r;
    vec_nxt    = vec_r;
    ready_nxt  = ready_r;
    done_nxt   = 1'b0;
    tmo_p_nxt  = 1'b0;
    irq_nxt    = ~filt_r[abp_pkg::HSY_IRQ];
    case (st_r)
      abp_pkg::HST_IDLE: begin
        if (req_valid_i && ready_r) begin
          // Address, direction and data settle one cycle before the strobe
          addr_nxt  = req_addr_i;
          rw_nxt    = (req_kind_i != abp_pkg::KIND_WRITE);
          dout_nxt  = req_wdata_i;
          doe_nxt   = (req_kind_i == abp_pkg::KIND_WRITE);
          vec_nxt   = (req_kind_i == abp_pkg::KIND_VECTOR);
          ready_nxt = 1'b0;
          st_nxt    = abp_pkg::HST_SETUP;
        end
      end
      abp_pkg::HST_SETUP: begin
        ce_n_nxt   = vec_r;
        iack_n_nxt = ~vec_r;
        tmo_nxt    = 16'h0000;
        st_nxt     = abp_pkg::HST_WAIT;
      end
      abp_pkg::HST_WAIT: begin
        if (ack_low_w || tmo_r == 16'(TIMEOUT_CYC - 1)) begin
          rdata_nxt  = data_f_w;
          tmo_p_nxt  = ~ack_low_w;
          ce_n_nxt   = 1'b1;
          iack_n_nxt = 1'b1;
          doe_nxt    = 1'b0;
          st_nxt     = abp_pkg::HST_RELEASE;
        end else begin
          tmo_nxt = tmo_r + 16'h0001;
        end
      end
      abp_pkg::HST_RELEASE: begin
        // Next cycle only after the device has let go of the acknowledge
        if (!ack_low_w) begin
          done_nxt  = 1'b1;
          ready_nxt = 1'b1;
          st_nxt    = abp_pkg::HST_IDLE;
        end
      end
      default: begin
        ce_n_nxt   = 1'b1;
        iack_n_nxt = 1'b1;
        doe_nxt    = 1'b0;
        ready_nxt  = 1'b1;
        st_nxt     = abp_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_r     <= abp_pkg::HST_IDLE;
      tmo_r    <= 16'h0000;
      ce_n_r   <= 1'b1;
      iack_n_r <= 1'b1;
      rw_r     <= 1'b1;
      addr_r   <= abp_pkg::ADDR_RST;
      dout_r   <= abp_pkg::DATA_RST;
      rdata_r  <= abp_pkg::DATA_RST;
      doe_r    <= 1'b0;
      vec_r    <= 1'b0;
      ready_r  <= 1'b1;
      done_r   <= 1'b0;
      tmo_p_r  <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      tmo_r    <= tmo_nxt;
      ce_n_r   <= ce_n_nxt;
      iack_n_r <= iack_n_nxt;
      rw_r     <= rw_nxt;
      addr_r   <= addr_nxt;
      dout_r   <= dout_nxt;
      rdata_r  <= rdata_nxt;
      doe_r    <= doe_nxt;
      vec_r    <= vec_nxt;
      ready_r  <= ready_nxt;
      done_r   <= done_nxt;
      tmo_p_r  <= tmo_p_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign bus.chip_enable_low       = ce_n_r;
  assign bus.vector_fetch_ack_in   = iack_n_r;
  assign bus.read_not_write        = rw_r;
  assign bus.register_select_lines = addr_r;
  assign bus.host_data_out         = dout_r;
  assign bus.host_data_oe          = doe_r;
  assign req_ready_o               = ready_r;
  assign done_o                    = done_r;
  assign timeout_o                 = tmo_p_r;
  assign rdata_o                   = rdata_r;
  assign irq_pending_o             = irq_r;

endmodule

`default_nettype wire

// >>> verilog/abp_dev.sv
// Behaviour
// - Strap low selects read/write plus acknowledge bus
// - Eight-bit three-state data bus, bit 0 LSB
// - Data driven only while chip enable or vector fetch low
// - Read/write high reads, low writes
// - Vector fetch drives vector and acknowledges
// - Open-drain low acknowledge on every cycle
// - Seven-bit register select decoded per cycle
// - Host fetches vector in answer to interrupt
// - Acknowledge at least two edges after enable
// - Interrupt output low while masked condition true
`default_nettype none

// ==========================================================================
// Device end: answers host cycles on the register port
module abp_dev #(
  parameter int unsigned ACK_EDGES = abp_pkg::ACK_DELAY_EDGES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  abp_if.device            bus,
  output logic [6:0]       reg_addr_o,
  output logic             reg_wr_o,
  output logic [7:0]       reg_wdata_o,
  output logic             reg_rd_o,
  input  wire logic [7:0]  reg_rdata_i,
  input  wire logic [7:0]  vector_i,
  output logic             vector_fetch_o,
  input  wire logic [10:0] irq_cond_i,
  input  wire logic [10:0] irq_mask_i,
  output logic             port_active_o
);

  if (ACK_EDGES < 2 || ACK_EDGES > 15) begin : g_chk
    $error("abp_dev: ACK_EDGES must lie in 2..15");
  end

  // ========================================================================
  // Pin synchroniser: a change counts once stages two and three agree
  logic [18:0] s1_r, s2_r, s3_r, filt_r;
  logic [18:0] raw_w, filt_nxt;

  always_comb begin
    raw_w = {bus.bus_style_strap, bus.vector_fetch_ack_in, bus.chip_enable_low,
             bus.read_not_write, bus.register_select_lines, bus.host_data_lines};
    filt_nxt = (s3_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s1_r   <= abp_pkg::DSY_RST;
      s2_r   <= abp_pkg::DSY_RST;
      s3_r   <= abp_pkg::DSY_RST;
      filt_r <= abp_pkg::DSY_RST;
    end else begin
      s1_r   <= raw_w;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  wire logic       strap_f_w = filt_nxt[abp_pkg::DSY_STRAP];
  wire logic       iack_f_w  = filt_r[abp_pkg::DSY_IACK];
  wire logic       ce_f_w    = filt_r[abp_pkg::DSY_CE];
  wire logic       rw_f_w    = filt_r[abp_pkg::DSY_RW];
  wire logic [6:0] addr_f_w  = filt_r[abp_pkg::DSY_ADDR_LSB +: 7];
  wire logic [7:0] data_f_w  = filt_r[abp_pkg::DSY_DATA_LSB +: 8];

  // ========================================================================
  // Strap capture: taken once after reset from the filter's next value, since
  // the registered filter output still shows its reset level at the capture edge
  logic [1:0] cap_cnt_r, cap_cnt_nxt;
  logic       cap_done_r, cap_done_nxt;
  logic       active_r, active_nxt;

  always_comb begin
    cap_cnt_nxt  = cap_cnt_r;
    cap_done_nxt = cap_done_r;
    active_nxt   = active_r;
    if (!cap_done_r) begin
      if (cap_cnt_r == 2'(abp_pkg::STRAP_SETTLE_CYC)) begin
        // The other bus style is not served here: no cycle is answered, only the interrupt line still follows its enabled conditions
        active_nxt   = ~strap_f_w;
        cap_done_nxt = 1'b1;
      end else begin
        cap_cnt_nxt = cap_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cap_cnt_r  <= 2'h0;
      cap_done_r <= 1'b0;
      active_r   <= 1'b0;
    end else begin
      cap_cnt_r  <= cap_cnt_nxt;
      cap_done_r <= cap_done_nxt;
      active_r   <= active_nxt;
    end
  end

  // ========================================================================
  // Cycle engine
  abp_pkg::abp_dev_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic       vec_r, vec_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt, dout_r, dout_nxt;
  logic       wr_r, wr_nxt, rd_r, rd_nxt, vf_r, vf_nxt;
  logic       doe_r, doe_nxt, ack_oe_r, ack_oe_nxt, irq_oe_r, irq_oe_nxt;
  logic       cyc_end;

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    vec_nxt    = vec_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    dout_nxt   = dout_r;
    wr_nxt     = 1'b0;
    rd_nxt     = 1'b0;
    vf_nxt     = 1'b0;
    doe_nxt    = doe_r;
    ack_oe_nxt = ack_oe_r;
    // Open drain: the line is pulled low while any enabled condition holds
    irq_oe_nxt = |(irq_cond_i & irq_mask_i);
    // A fetch ends with its own strobe; register cycles end with enable
    cyc_end    = vec_r ? iack_f_w : ce_f_w;
    case (st_r)
      abp_pkg::DEV_IDLE: begin
        doe_nxt    = 1'b0;
        ack_oe_nxt = 1'b0;
        if (active_r && (!iack_f_w || !ce_f_w)) begin
          // A vector fetch wins over a register cycle seen at once
          vec_nxt = ~iack_f_w;
          cnt_nxt = 4'h0;
          st_nxt  = abp_pkg::DEV_SETUP;
        end
      end
      abp_pkg::DEV_SETUP: begin
        if (cyc_end) begin
          st_nxt = abp_pkg::DEV_IDLE;
        end else if (cnt_r == 4'(ACK_EDGES - 1)) begin
          if (vec_r) begin
            dout_nxt   = vector_i;
            doe_nxt    = 1'b1;
            ack_oe_nxt = 1'b1;
            vf_nxt     = 1'b1;
            st_nxt     = abp_pkg::DEV_ACK;
          end else if (rw_f_w) begin
            addr_nxt = addr_f_w;
            rd_nxt   = 1'b1;
            st_nxt   = abp_pkg::DEV_FETCH;
          end else begin
            // Write data is latched on the same edge that raises the acknowledge
            addr_nxt   = addr_f_w;
            wdata_nxt  = data_f_w;
            wr_nxt     = 1'b1;
            ack_oe_nxt = 1'b1;
            st_nxt     = abp_pkg::DEV_ACK;
          end
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      abp_pkg::DEV_FETCH: begin
        if (cyc_end) begin
          st_nxt = abp_pkg::DEV_IDLE;
        end else begin
          // Read data is expected combinationally while the read strobe is high
          dout_nxt   = reg_rdata_i;
          doe_nxt    = 1'b1;
          ack_oe_nxt = 1'b1;
          st_nxt     = abp_pkg::DEV_ACK;
        end
      end
      abp_pkg::DEV_ACK: begin
        if (cyc_end) begin
          doe_nxt    = 1'b0;
          ack_oe_nxt = 1'b0;
          st_nxt     = abp_pkg::DEV_IDLE;
        end
      end
      default: begin
        doe_nxt    = 1'b0;
        ack_oe_nxt = 1'b0;
        st_nxt     = abp_pkg::DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_r     <= abp_pkg::DEV_IDLE;
      cnt_r    <= 4'h0;
      vec_r    <= 1'b0;
      addr_r   <= abp_pkg::ADDR_RST;
      wdata_r  <= abp_pkg::DATA_RST;
      dout_r   <= abp_pkg::DATA_RST;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
      vf_r     <= 1'b0;
      doe_r    <= 1'b0;
      ack_oe_r <= 1'b0;
      irq_oe_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      vec_r    <= vec_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      dout_r   <= dout_nxt;
      wr_r     <= wr_nxt;
      rd_r     <= rd_nxt;
      vf_r     <= vf_nxt;
      doe_r    <= doe_nxt;
      ack_oe_r <= ack_oe_nxt;
      irq_oe_r <= irq_oe_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign bus.dev_data_out         = dout_r;
  assign bus.dev_data_oe          = doe_r;
  assign bus.transfer_done_ack_oe = ack_oe_r;
  assign bus.interrupt_request_oe = irq_oe_r;
  assign reg_addr_o               = addr_r;
  assign reg_wr_o                 = wr_r;
  assign reg_wdata_o              = wdata_r;
  assign reg_rd_o                 = rd_r;
  assign vector_fetch_o           = vf_r;
  assign port_active_o            = active_r;

endmodule

`default_nettype wire

// >>> dv/abp_sva.sv
`default_nettype none

// ==========================================================================
// Pin-level checks between the host end and the device end
module abp_sva (
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic       chip_enable_low,
  input wire logic       read_not_write,
  input wire logic       vector_fetch_ack_in,
  input wire logic       bus_style_strap,
  input wire logic [7:0] dev_data_out,
  input wire logic       dev_data_oe,
  input wire logic       transfer_done_ack_oe,
  input wire logic       interrupt_request_oe
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  ack_delay_a : assert property (
    $fell(chip_enable_low) |-> !transfer_done_ack_oe [*3])
    else $error("acknowledge came too early after enable");
  ack_answer_a : assert property (
    $fell(chip_enable_low) && !bus_style_strap |-> ##[2:12] transfer_done_ack_oe)
    else $error("register cycle not acknowledged");
  vec_answer_a : assert property (
    $fell(vector_fetch_ack_in) |-> ##[2:12] (transfer_done_ack_oe && dev_data_oe))
    else $error("vector fetch not answered");
  dir_drive_a : assert property (
    $rose(transfer_done_ack_oe) && vector_fetch_ack_in |-> dev_data_oe == read_not_write)
    else $error("data drive does not follow direction");
  ce_release_a : assert property (
    $rose(chip_enable_low) && vector_fetch_ack_in
    |-> ##[1:8] (!dev_data_oe && !transfer_done_ack_oe))
    else $error("bus not released after enable");
  vec_release_a : assert property (
    $rose(vector_fetch_ack_in) && chip_enable_low
    |-> ##[1:8] (!dev_data_oe && !transfer_done_ack_oe))
    else $error("bus not released after vector fetch");
  drive_cause_a : assert property (
    $rose(dev_data_oe) |-> (!chip_enable_low || !vector_fetch_ack_in))
    else $error("data driven with no cycle open");
  ack_hold_a : assert property (
    transfer_done_ack_oe && !chip_enable_low |=> transfer_done_ack_oe)
    else $error("acknowledge dropped while enable low");
  data_hold_a : assert property (
    dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data_out))
    else $error("driven data changed in mid cycle");

  cover property ($rose(transfer_done_ack_oe) && read_not_write && vector_fetch_ack_in);
  cover property ($rose(transfer_done_ack_oe) && !read_not_write && vector_fetch_ack_in);
  cover property ($rose(transfer_done_ack_oe) && !vector_fetch_ack_in);
  cover property ($rose(interrupt_request_oe));
endmodule

`default_nettype wire

// >>> dv/test_async_host_bus_port.sv
`default_nettype none

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

// ==========================================================================
// Host and device joined back to back; a register file stands behind the device
module test_async_host_bus_port;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i;
  logic        reset_n_i;
  logic        req_valid_i;
  logic [1:0]  req_kind_i;
  logic [6:0]  req_addr_i;
  logic [7:0]  req_wdata_i;
  logic        req_ready_o;
  logic        done_o;
  logic        timeout_o;
  logic [7:0]  rdata_o;
  logic        irq_pending_o;
  logic [6:0]  reg_addr_o;
  logic        reg_wr_o;
  logic [7:0]  reg_wdata_o;
  logic        reg_rd_o;
  logic [7:0]  reg_rdata_i;
  logic [7:0]  vector_i;
  logic        vector_fetch_o;
  logic [10:0] irq_cond_i;
  logic [10:0] irq_mask_i;
  logic        port_active_o;
  logic [7:0]  regfile [128];
  int          model [128];
  logic [7:0]  exp_bus;
  logic [6:0]  exp_addr;
  logic [1:0]  exp_kind;
  logic [1:0]  op_kind;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          tout_cnt = 0;
  int          vec_cnt = 0;
  int          nvec = 0;
  int          seed;

  abp_if bus ();

  abp_host #(.TIMEOUT_CYC(32)) i_abp_host (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(bus),
    .req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .timeout_o(timeout_o), .rdata_o(rdata_o), .irq_pending_o(irq_pending_o));

  abp_dev i_abp_dev (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(bus),
    .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
    .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i), .vector_i(vector_i),
    .vector_fetch_o(vector_fetch_o), .irq_cond_i(irq_cond_i), .irq_mask_i(irq_mask_i),
    .port_active_o(port_active_o));

  abp_sva i_abp_sva (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .chip_enable_low(bus.chip_enable_low), .read_not_write(bus.read_not_write),
    .vector_fetch_ack_in(bus.vector_fetch_ack_in), .bus_style_strap(bus.bus_style_strap),
    .dev_data_out(bus.dev_data_out), .dev_data_oe(bus.dev_data_oe),
    .transfer_done_ack_oe(bus.transfer_done_ack_oe),
    .interrupt_request_oe(bus.interrupt_request_oe));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  assign reg_rdata_i = regfile[reg_addr_o];

  task automatic report_and_stop();
    $display("Checks made: %0d, mismatches: %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog sized far above the roughly 1500 cycles the sequence needs
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (reg_wr_o === 1'b1) regfile[reg_addr_o] <= reg_wdata_o;
    if (timeout_o === 1'b1) tout_cnt <= tout_cnt + 1;
    if (vector_fetch_o === 1'b1) vec_cnt <= vec_cnt + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  always @(negedge sys_clk_i) begin
    if (reg_wr_o === 1'b1 || reg_rd_o === 1'b1) `CHK("reg_addr", exp_addr, reg_addr_o)
    if (reg_wr_o === 1'b1) `CHK("reg_wdata", exp_bus, reg_wdata_o)
    if (bus.transfer_done_ack === 1'b0 && exp_kind != abp_pkg::KIND_WRITE)
      `CHK("data_lines", exp_bus, bus.host_data_lines)
  end

  task automatic do_op(input logic [1:0] k, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    exp_kind = k;
    exp_addr = a;
    exp_bus = (k == abp_pkg::KIND_READ) ? 8'(model[a]) : d;
    @(negedge sys_clk_i);
    while (req_ready_o !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (k == abp_pkg::KIND_VECTOR) vector_i = d;
    req_valid_i = 1'b1;
    req_kind_i = k;
    req_addr_i = a;
    req_wdata_i = d;
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    `CHK("op_done", 1'b1, done_o)
    if (k == abp_pkg::KIND_WRITE) model[a] = d;
    else if (bus.bus_style_strap === 1'b0) `CHK("rdata", exp_bus, rdata_o)
    else `CHK("rdata_float", 8'hFF, rdata_o)
    `CHK("idle_lines", 8'hFF, bus.host_data_lines)
    `CHK("ack_idle", 1'b1, bus.transfer_done_ack)
  endtask

  initial begin
    reset_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_kind_i = 2'h0;
    req_addr_i = 7'h00;
    req_wdata_i = 8'h00;
    vector_i = 8'h00;
    irq_cond_i = 11'h000;
    irq_mask_i = 11'h000;
    exp_kind = abp_pkg::KIND_WRITE;
    bus.bus_style_strap = 1'b0;
    seed = $urandom(32'h9693);
    for (int i = 0; i < 128; i++) begin
      regfile[i] = 8'($urandom);
      model[i] = regfile[i];
    end
    repeat (6) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    `CHK("port_active", 1'b1, port_active_o)
    // Select boundaries first, then a random mix with back-to-back cycles
    do_op(abp_pkg::KIND_WRITE, 7'h7F, 8'hA5);
    do_op(abp_pkg::KIND_WRITE, 7'h00, 8'h5A);
    do_op(abp_pkg::KIND_READ, 7'h7F, 8'h00);
    do_op(abp_pkg::KIND_READ, 7'h00, 8'h00);
    for (int i = 0; i < 40; i++) begin
      op_kind = 2'($urandom_range(2));
      if (op_kind == abp_pkg::KIND_VECTOR) nvec++;
      do_op(op_kind, 7'($urandom), 8'($urandom));
    end
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk_i);
      irq_cond_i = (i == 0) ? 11'h000 : (i == 1) ? 11'h400 : 11'($urandom);
      irq_mask_i = (i == 7) ? 11'h000 : (i == 1) ? 11'h400 : 11'($urandom);
      repeat (8) @(negedge sys_clk_i);
      `CHK("irq_line", ~|(irq_cond_i & irq_mask_i), bus.interrupt_request_out)
      `CHK("irq_pending", |(irq_cond_i & irq_mask_i), irq_pending_o)
      if (irq_pending_o === 1'b1) begin
        nvec++;
        do_op(abp_pkg::KIND_VECTOR, 7'h00, 8'($urandom));
      end
    end
    `CHK("timeouts", 0, tout_cnt)
    `CHK("vector_fetches", nvec, vec_cnt)
    // Strap high at capture: the port must stay silent and the host times out
    @(negedge sys_clk_i);
    bus.bus_style_strap = 1'b1;
    reset_n_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    `CHK("port_active", 1'b0, port_active_o)
    do_op(abp_pkg::KIND_READ, 7'h11, 8'h00);
    `CHK("timeouts", 1, tout_cnt)
    report_and_stop();
  end
endmodule

`default_nettype wire
